// ==== rtl/cfb_pkg.sv ====
// package for the acceptance filter / bus-off / error counter register block
// assumes a byte-wide register port with offsets as below
`default_nettype none
package cfb_pkg;
   // register offsets
   localparam logic [5:0] OFS_CTL1 = 6'h01;
   localparam logic [5:0] OFS_IDAC = 6'h0B;
   localparam logic [5:0] OFS_TEST = 6'h0C;
   localparam logic [5:0] OFS_MISC = 6'h0D;
   localparam logic [5:0] OFS_RXERR = 6'h0E;
   localparam logic [5:0] OFS_TXERR = 6'h0F;
   localparam logic [5:0] OFS_CODE_LO = 6'h10;
   localparam logic [5:0] OFS_CODE_HI = 6'h14;
   localparam logic [5:0] OFS_MASK_LO = 6'h18;
   localparam logic [5:0] OFS_MASK_HI = 6'h1C;
   localparam logic [5:0] OFS_STAT = 6'h20;
   // field positions
   localparam int CTL1_RECOVERY_SELECT_BIT = 3;
   localparam int CTL1_SLEEP_REQUEST_BIT = 1;
   localparam int CTL1_INIT_REQUEST_BIT = 0;
   localparam int IDAC_MODE_LSB = 4;
   localparam int MISC_HOLD_BIT = 0;
   localparam int STAT_SLEEP_ACK_BIT = 1;
   localparam int STAT_INIT_ACK_BIT = 0;
   localparam int STAT_BUSOFF_BIT = 2;
   localparam int STAT_ACCEPT_BIT = 3;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [1:0] RST_MODE = 2'h0;
   // fault confinement figures
   localparam logic [8:0] TEC_BUSOFF = 9'h100;
   localparam logic [7:0] ERR_PASSIVE = 8'h80;
   localparam logic [7:0] ERR_STEP_TX = 8'h08;
   localparam logic [7:0] ERR_STEP_RX = 8'h01;
   localparam logic [10:0] RECOVER_BITS = 11'h580;
   // filter organization codes
   typedef enum logic [1:0]
   {
      CFB_FILT_32 = 2'h0,
      CFB_FILT_16 = 2'h1,
      CFB_FILT_8 = 2'h2,
      CFB_FILT_CLOSED = 2'h3
   } cfb_filt_e;
   // bus-off state machine, gray along the path through CFB_HOLD
   typedef enum logic [1:0]
   {
      CFB_ACTIVE = 2'h0,
      CFB_BUSOFF = 2'h1,
      CFB_HOLD = 2'h3,
      CFB_RECOVER = 2'h2
   } cfb_state_e;
endpackage
`default_nettype wire

// ==== rtl/cfb_code_mem.sv ====
// small byte memory holding the acceptance code and mask bytes
// assumes writes are already qualified by the caller; read data registered
`timescale 1ns/1ns
`default_nettype none
module cfb_code_mem
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_wr,
   input wire logic [3:0] i_waddr,
   input wire logic [7:0] i_wdata,
   input wire logic [3:0] i_raddr,
   output logic [7:0] o_rdata,
   output logic [127:0] o_all
);
   logic [7:0] mem [16];

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         for (int k = 0; k < 16; k++)
            mem[k] <= cfb_pkg::RST_BYTE;
      end
      else if (i_wr)
      begin
         mem[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         o_rdata <= cfb_pkg::RST_BYTE;
      else
         o_rdata <= mem[i_raddr];
   end

   always_comb
   begin
      for (int k = 0; k < 16; k++)
         o_all[k*8 +: 8] = mem[k];
   end
endmodule
`default_nettype wire

// ==== rtl/cfb_regs.sv ====
// acceptance filter, bus-off hold and error counter registers of a can controller
// assumes the protocol engine supplies one-cycle error event pulses and a
// received identifier with a done strobe; mode acknowledges come in as levels
//
// Summary of operation
// - test register reads zero, writes ignored
// - with recovery select, hold bus-off until request
// - clearing hold flag starts bus-off recovery
// - write one clears flag, zero ignored
// - receive count readable only in sleep/init
// - transmit count readable only in sleep/init
// - every message buffered, only accepted ones signalled
// - code bytes compared bitwise with identifier bytes
// - in 32-bit organization extended uses four pairs, standard two; 16-bit uses two, 8-bit one
// - code compare qualified by mask byte
// - code bytes writable only in init mode
// - clear mask bit must match, set ignored
// - organization selects 32/16/8 bit or closed
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module cfb_regs
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [5:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_sleep_acknowledge,
   input wire logic i_init_acknowledge,
   input wire logic i_tx_error,
   input wire logic i_rx_error,
   input wire logic i_tx_ok,
   input wire logic i_rx_ok,
   input wire logic i_recessive_bit,
   input wire logic i_rx_done,
   input wire logic i_rx_extended,
   input wire logic [31:0] i_identifier_bytes,
   output logic o_rx_buffer_load,
   output logic o_rx_accept,
   output logic [2:0] o_filter_hit,
   output logic o_busoff
);
   // ------------------------------------------------------------
   // mode and control bits
   // ------------------------------------------------------------
   logic [7:0] control_reg_one;
   logic [1:0] filter_organization;
   logic busoff_hold_flag;
   logic [7:0] receive_error_count;
   logic [8:0] tec;
   cfb_pkg::cfb_state_e state;
   logic [10:0] recover_cnt;
   logic [127:0] code_mask;
   logic [7:0] mem_rdata;
   logic mem_rd_q;
   logic [7:0] next_rdata;
   logic init_mode;
   logic sleep_mode;
   logic busoff_recovery_select;
   logic code_wr;
   logic [3:0] mem_addr;

   assign busoff_recovery_select = control_reg_one[cfb_pkg::CTL1_RECOVERY_SELECT_BIT];
   assign init_mode = control_reg_one[cfb_pkg::CTL1_INIT_REQUEST_BIT] & i_init_acknowledge;
   assign sleep_mode = control_reg_one[cfb_pkg::CTL1_SLEEP_REQUEST_BIT] & i_sleep_acknowledge;

   function automatic logic in_code_space(input logic [5:0] a);
      in_code_space = (a >= cfb_pkg::OFS_CODE_LO) && (a < cfb_pkg::OFS_STAT);
   endfunction

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         control_reg_one <= cfb_pkg::RST_BYTE;
      else if (i_wr && i_addr == cfb_pkg::OFS_CTL1)
         control_reg_one <= i_wdata;
   end

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         filter_organization <= cfb_pkg::RST_MODE;
      else if (i_wr && i_addr == cfb_pkg::OFS_IDAC && init_mode)
         filter_organization <= i_wdata[cfb_pkg::IDAC_MODE_LSB +: 2];
   end

   // ------------------------------------------------------------
   // acceptance code and mask storage
   // ------------------------------------------------------------
   // init-only writes
   assign code_wr = i_wr && in_code_space(i_addr) && init_mode;
   assign mem_addr = i_addr[3:0];

   cfb_code_mem u_mem
   (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_wr(code_wr),
      .i_waddr(mem_addr),
      .i_wdata(i_wdata),
      .i_raddr(mem_addr),
      .o_rdata(mem_rdata),
      .o_all(code_mask)
   );

   // ------------------------------------------------------------
   // fault confinement counters
   // ------------------------------------------------------------
   // counter updates
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         receive_error_count <= cfb_pkg::RST_BYTE;
      else if (state == cfb_pkg::CFB_RECOVER && recover_cnt == '0)
         receive_error_count <= cfb_pkg::RST_BYTE;
      else if (i_rx_error && receive_error_count != 8'hFF)
         receive_error_count <= receive_error_count + cfb_pkg::ERR_STEP_RX;
      else if (i_rx_ok && receive_error_count > cfb_pkg::ERR_PASSIVE)
         receive_error_count <= cfb_pkg::ERR_PASSIVE - cfb_pkg::ERR_STEP_TX;
      else if (i_rx_ok && receive_error_count != 8'h00)
         receive_error_count <= receive_error_count - cfb_pkg::ERR_STEP_RX;
   end

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         tec <= 9'h000;
      else if (state == cfb_pkg::CFB_RECOVER && recover_cnt == '0)
         tec <= 9'h000;
      else if (state != cfb_pkg::CFB_ACTIVE)
         tec <= tec;
      else if (i_tx_error)
         tec <= tec + {1'b0, cfb_pkg::ERR_STEP_TX};
      else if (i_tx_ok && tec != 9'h000)
         tec <= tec - 9'h001;
   end

   // ------------------------------------------------------------
   // bus-off handling
   // ------------------------------------------------------------
   logic hold_clear;
   assign hold_clear = i_wr && i_addr == cfb_pkg::OFS_MISC && i_wdata[cfb_pkg::MISC_HOLD_BIT];

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state <= cfb_pkg::CFB_ACTIVE;
      end
      else
      begin
         case (state)
            cfb_pkg::CFB_ACTIVE:
               if (tec >= cfb_pkg::TEC_BUSOFF)
                  state <= cfb_pkg::CFB_BUSOFF;
            cfb_pkg::CFB_BUSOFF:
               if (busoff_recovery_select)
                  state <= cfb_pkg::CFB_HOLD;
               else
                  state <= cfb_pkg::CFB_RECOVER;
            cfb_pkg::CFB_HOLD:
               if (hold_clear || !busoff_recovery_select)
                  state <= cfb_pkg::CFB_RECOVER;
            cfb_pkg::CFB_RECOVER:
               if (recover_cnt == '0)
                  state <= cfb_pkg::CFB_ACTIVE;
            default:
               state <= cfb_pkg::CFB_ACTIVE;
         endcase
      end
   end

   // recovery waits for recessive bits, counted as the engine reports them
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         recover_cnt <= cfb_pkg::RECOVER_BITS;
      else if (state != cfb_pkg::CFB_RECOVER)
         recover_cnt <= cfb_pkg::RECOVER_BITS;
      else if (i_recessive_bit && recover_cnt != '0)
         recover_cnt <= recover_cnt - 11'h001;
   end

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         busoff_hold_flag <= 1'b0;
      else
         busoff_hold_flag <= busoff_recovery_select
                             && (state == cfb_pkg::CFB_BUSOFF
                                 || (state == cfb_pkg::CFB_HOLD && !hold_clear));
   end

   assign o_busoff = (state != cfb_pkg::CFB_ACTIVE);

   // ------------------------------------------------------------
   // acceptance filter
   // ------------------------------------------------------------
   // bitwise compare
   function automatic logic byte_hit(input logic [7:0] id, input logic [7:0] code,
                                     input logic [7:0] mask);
      byte_hit = &((~(id ^ code)) | mask);
   endfunction

   logic [7:0] hit_vec;
   logic [7:0] idb [4];
   logic [7:0] cb [8];
   logic [7:0] mb [8];

   always_comb
   begin
      for (int k = 0; k < 4; k++)
         idb[k] = i_identifier_bytes[31 - 8*k -: 8];
      for (int k = 0; k < 8; k++)
      begin
         cb[k] = code_mask[k*8 +: 8];
         mb[k] = code_mask[64 + k*8 +: 8];
      end
   end

   always_comb
   begin
      hit_vec = 8'h00;
      case (cfb_pkg::cfb_filt_e'(filter_organization))
         cfb_pkg::CFB_FILT_32:
            for (int f = 0; f < 2; f++)
               hit_vec[f] = byte_hit(idb[0], cb[4*f], mb[4*f])
                            && byte_hit(idb[1], cb[4*f+1], mb[4*f+1])
                            && (!i_rx_extended
                                || (byte_hit(idb[2], cb[4*f+2], mb[4*f+2])
                                    && byte_hit(idb[3], cb[4*f+3], mb[4*f+3])));
         cfb_pkg::CFB_FILT_16:
            for (int f = 0; f < 4; f++)
               hit_vec[f] = byte_hit(idb[0], cb[2*f], mb[2*f])
                            && byte_hit(idb[1], cb[2*f+1], mb[2*f+1]);
         cfb_pkg::CFB_FILT_8:
            for (int f = 0; f < 8; f++)
               hit_vec[f] = byte_hit(idb[0], cb[f], mb[f]);
         default:
            hit_vec = 8'h00;
      endcase
   end

   logic [2:0] first_hit;
   always_comb
   begin
      first_hit = 3'h0;
      for (int f = 7; f >= 0; f--)
         if (hit_vec[f])
            first_hit = f[2:0];
   end

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_rx_buffer_load <= 1'b0;
         o_rx_accept <= 1'b0;
         o_filter_hit <= 3'h0;
      end
      else
      begin
         o_rx_buffer_load <= i_rx_done;
         o_rx_accept <= i_rx_done && (hit_vec != 8'h00);
         if (i_rx_done && hit_vec != 8'h00)
            o_filter_hit <= first_hit;
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         mem_rd_q <= 1'b0;
      else
         mem_rd_q <= i_rd && in_code_space(i_addr);
   end

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         next_rdata <= cfb_pkg::RST_BYTE;
      else if (!i_rd)
         next_rdata <= cfb_pkg::RST_BYTE;
      else
      begin
         case (i_addr)
            cfb_pkg::OFS_CTL1:
               next_rdata <= control_reg_one;
            cfb_pkg::OFS_IDAC:
               next_rdata <= {2'b00, filter_organization, 1'b0, o_filter_hit};
            cfb_pkg::OFS_TEST:
               next_rdata <= cfb_pkg::RST_BYTE;
            cfb_pkg::OFS_MISC:
               next_rdata <= {7'h00, busoff_hold_flag};
            cfb_pkg::OFS_RXERR:
               next_rdata <= (sleep_mode || init_mode) ? receive_error_count
                                                       : cfb_pkg::RST_BYTE;
            cfb_pkg::OFS_TXERR:
               next_rdata <= (sleep_mode || init_mode) ? tec[7:0] : cfb_pkg::RST_BYTE;
            cfb_pkg::OFS_STAT:
               next_rdata <= {4'h0, o_rx_accept, o_busoff, i_sleep_acknowledge,
                              i_init_acknowledge};
            default:
               next_rdata <= cfb_pkg::RST_BYTE;
         endcase
      end
   end

   assign o_rdata = mem_rd_q ? mem_rdata : next_rdata;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_TEST_ZERO: assert property (@(posedge i_core_clk) disable iff (i_rst)
      i_rd && i_addr == cfb_pkg::OFS_TEST |=> o_rdata == 8'h00)
      else $error("test register read not zero");
   AST_HOLD_SET: assert property (@(posedge i_core_clk) disable iff (i_rst)
      state == cfb_pkg::CFB_BUSOFF && busoff_recovery_select && !hold_clear
      |=> busoff_hold_flag)
      else $error("hold flag not set on bus-off");
   AST_HOLD_STAYS: assert property (@(posedge i_core_clk) disable iff (i_rst)
      state == cfb_pkg::CFB_HOLD && !hold_clear && busoff_recovery_select
      |=> state == cfb_pkg::CFB_HOLD)
      else $error("left hold without request");
   AST_CLEAR: assert property (@(posedge i_core_clk) disable iff (i_rst)
      state == cfb_pkg::CFB_HOLD && hold_clear |=> !busoff_hold_flag
      ##0 state == cfb_pkg::CFB_RECOVER)
      else $error("hold clear did not start recovery");
   AST_RX_GATE: assert property (@(posedge i_core_clk) disable iff (i_rst)
      i_rd && i_addr == cfb_pkg::OFS_RXERR && !sleep_mode && !init_mode |=> o_rdata == 8'h00)
      else $error("receive count leaked outside sleep/init");
   AST_TX_READ: assert property (@(posedge i_core_clk) disable iff (i_rst)
      i_rd && i_addr == cfb_pkg::OFS_TXERR && init_mode |=> o_rdata == $past(tec[7:0]))
      else $error("transmit count read wrong");
   AST_LOAD: assert property (@(posedge i_core_clk) disable iff (i_rst)
      i_rx_done |=> o_rx_buffer_load ##0 (o_rx_accept == $past(hit_vec != 8'h00)))
      else $error("receive load or accept wrong");
   AST_CLOSED: assert property (@(posedge i_core_clk) disable iff (i_rst)
      filter_organization == cfb_pkg::CFB_FILT_CLOSED && i_rx_done |=> !o_rx_accept)
      else $error("closed filter accepted");
   AST_NO_HOLD: assert property (@(posedge i_core_clk) disable iff (i_rst)
      !busoff_recovery_select ##1 !busoff_recovery_select |-> !busoff_hold_flag)
      else $error("hold flag set without recovery select");
endmodule
`default_nettype wire

// ==== dv/cfb_bus_model.sv ====
// far-side model: protocol engine event pulses and received identifiers
// assumes one bench process calls its tasks; outputs move after a rising edge
`timescale 1ns/1ns
`default_nettype none
module cfb_bus_model
(
   input wire logic i_core_clk,
   output logic o_tx_error,
   output logic o_rx_error,
   output logic o_tx_ok,
   output logic o_rx_ok,
   output logic o_recessive_bit,
   output logic o_rx_done,
   output logic o_rx_extended,
   output logic [31:0] o_identifier_bytes
);
   logic [4:0] ev = 5'h00;
   assign {o_recessive_bit, o_rx_ok, o_tx_ok, o_rx_error, o_tx_error} = ev;
   initial
   begin
      o_rx_done = 1'b0;
      o_rx_extended = 1'b0;
      o_identifier_bytes = 32'h0000_0000;
   end
   // kind 0 tx error, 1 rx error, 2 tx ok, 3 rx ok, 4 recessive bit
   task automatic pulse(input int kind, input int n);
      repeat (n)
      begin
         @(posedge i_core_clk);
         ev <= 5'(1 << kind);
         @(posedge i_core_clk);
         ev <= 5'h00;
      end
   endtask
   // lines show the inverse outside the strobe, so a stale value never matches
   task automatic send(input logic [31:0] id, input logic ext);
      @(posedge i_core_clk);
      o_identifier_bytes <= id;
      o_rx_extended <= ext;
      o_rx_done <= 1'b1;
      @(posedge i_core_clk);
      o_rx_done <= 1'b0;
      o_identifier_bytes <= ~id;
      o_rx_extended <= ~ext;
   endtask
endmodule
`default_nettype wire

// ==== dv/cfb_regs_tb_top.sv ====
// self-checking bench for the filter, bus-off and error counter registers
// assumes cfb_bus_model as far side; mode acknowledges are driven here
`timescale 1ns/1ns
`default_nettype none
module cfb_regs_tb_top;
   logic clk, rst, wr_s, rd_s, sa, ia, tx_e, rx_e, tx_k, rx_k, rb, rdn, ext, ld, acc, bo;
   logic [5:0] addr;
   logic [7:0] wdata, rdata;
   logic [31:0] idb, id, seed;
   logic [2:0] fh, hit;
   logic [7:0] code [8];
   logic [7:0] mask [8];
   int fail_count, tests_run, tec, rec, org, i, m, n, sel;
   int cycles = 0;

   cfb_regs i_cfb_regs (.i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_sleep_acknowledge(sa),
      .i_init_acknowledge(ia), .i_tx_error(tx_e), .i_rx_error(rx_e), .i_tx_ok(tx_k),
      .i_rx_ok(rx_k), .i_recessive_bit(rb), .i_rx_done(rdn), .i_rx_extended(ext),
      .i_identifier_bytes(idb), .o_rx_buffer_load(ld), .o_rx_accept(acc),
      .o_filter_hit(fh), .o_busoff(bo));
   cfb_bus_model i_cfb_bus_model (.i_core_clk(clk), .o_tx_error(tx_e), .o_rx_error(rx_e),
      .o_tx_ok(tx_k), .o_rx_ok(rx_k), .o_recessive_bit(rb), .o_rx_done(rdn),
      .o_rx_extended(ext), .o_identifier_bytes(idb));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // the whole run needs some 9200 cycles
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         fail_count++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      chk(rdata, exp);
   endtask
   // control bit0 init, bit1 sleep; the acks follow as the mode logic would
   task automatic mode(input logic [7:0] v);
      wr(cfb_pkg::OFS_CTL1, v);
      ia <= v[0];
      sa <= v[1];
      repeat (2) @(posedge clk);
   endtask
   task automatic chkb(input logic e);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({7'h00, bo}, {7'h00, e});
   endtask
   // lowest filter whose unmasked bits all match, or -1
   function automatic int model_hit(input logic [31:0] v, input logic x);
      int nf, nb, f, b, ok;
      nf = (org == 0) ? 2 : (org == 1) ? 4 : (org == 2) ? 8 : 0;
      nb = (org == 0) ? (x ? 4 : 2) : (org == 1) ? 2 : 1;
      for (f = 0; f < nf; f++)
      begin
         ok = 1;
         for (b = 0; b < nb; b++)
            if (((v[31-8*b -: 8] ^ code[f*(8/nf)+b]) & ~mask[f*(8/nf)+b]) != 8'h00)
               ok = 0;
         if (ok == 1)
            return f;
      end
      return -1;
   endfunction
   task automatic msg(input logic [31:0] v, input logic x);
      int h;
      h = model_hit(v, x);
      i_cfb_bus_model.send(v, x);
      @(negedge clk);
      chk({7'h00, ld}, 8'h01);
      chk({7'h00, acc}, {7'h00, h >= 0});
      if (h >= 0)
         hit = 3'(h);
      chk({5'h00, fh}, {5'h00, hit});
   endtask
   task automatic busoff_run(input logic held);
      mode({4'h0, held, 3'h0});
      i_cfb_bus_model.pulse(0, (256 - tec + 7) / 8 - 1);
      chkb(1'b0);
      i_cfb_bus_model.pulse(0, 1);
      chkb(1'b1);
      rdchk(cfb_pkg::OFS_STAT, 8'(1 << cfb_pkg::STAT_BUSOFF_BIT));
      rdchk(cfb_pkg::OFS_MISC, {7'h00, held});
      wr(cfb_pkg::OFS_MISC, 8'h00);
      rdchk(cfb_pkg::OFS_MISC, {7'h00, held});
      if (held)
      begin
         i_cfb_bus_model.pulse(4, 1408);
         chkb(1'b1);
      end
      wr(cfb_pkg::OFS_MISC, 8'h01);
      rdchk(cfb_pkg::OFS_MISC, 8'h00);
      i_cfb_bus_model.pulse(4, 1407);
      chkb(1'b1);
      i_cfb_bus_model.pulse(4, 1);
      chkb(1'b0);
      tec = 0;
      rec = 0;
      mode(8'h01);
      rdchk(cfb_pkg::OFS_TXERR, 8'h00);
      rdchk(cfb_pkg::OFS_RXERR, 8'h00);
      $display("bus-off test done, held %0d", held);
   endtask

   initial
   begin
      rst = 1'b1;
      addr = 6'h00;
      wdata = 8'h00;
      wr_s = 1'b0;
      rd_s = 1'b0;
      sa = 1'b0;
      ia = 1'b0;
      fail_count = 0;
      tests_run = 0;
      hit = 3'h0;
      seed = $urandom(6);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // test register touched in normal mode only
      wr(cfb_pkg::OFS_TEST, 8'hFF);
      rdchk(cfb_pkg::OFS_TEST, 8'h00);
      rdchk(6'h3F, 8'h00);
      $display("reserved test done");
      mode(8'h01);
      for (i = 0; i < 8; i++)
      begin
         code[i] = 8'($urandom);
         mask[i] = 8'($urandom & $urandom);
         wr(6'(cfb_pkg::OFS_CODE_LO + i), code[i]);
         wr(6'(cfb_pkg::OFS_MASK_LO + i), mask[i]);
      end
      for (i = 0; i < 8; i++)
      begin
         rdchk(6'(cfb_pkg::OFS_CODE_LO + i), code[i]);
         rdchk(6'(cfb_pkg::OFS_MASK_LO + i), mask[i]);
      end
      mode(8'h00);
      wr(cfb_pkg::OFS_CODE_LO, ~code[0]);
      rdchk(cfb_pkg::OFS_CODE_LO, code[0]);
      $display("code register test done");
      for (m = 0; m < 4; m++)
      begin
         mode(8'h01);
         org = m;
         wr(cfb_pkg::OFS_IDAC, 8'(m << 4));
         mode(8'h00);
         repeat (16)
         begin
            sel = $urandom % 2;
            id = {code[4*sel], code[4*sel+1], code[4*sel+2], code[4*sel+3]};
            id = id ^ ($urandom & {mask[4*sel], mask[4*sel+1], mask[4*sel+2], mask[4*sel+3]});
            if ($urandom % 3 == 0)
               id = id ^ (32'h0000_0001 << ($urandom % 32));
            msg(id, 1'($urandom % 2));
         end
         rdchk(cfb_pkg::OFS_IDAC, {2'h0, 2'(m), 1'b0, hit});
      end
      $display("filter test done");
      // counts read in sleep or init, except the refused reads
      n = 1 + $urandom % 20;
      i_cfb_bus_model.pulse(1, n);
      i_cfb_bus_model.pulse(3, 1);
      rec = n - 1;
      n = 1 + $urandom % 10;
      i_cfb_bus_model.pulse(0, n);
      i_cfb_bus_model.pulse(2, 1);
      tec = 8 * n - 1;
      rdchk(cfb_pkg::OFS_RXERR, 8'h00);
      wr(cfb_pkg::OFS_CTL1, 8'h02);
      rdchk(cfb_pkg::OFS_TXERR, 8'h00);
      mode(8'h02);
      rdchk(cfb_pkg::OFS_RXERR, 8'(rec));
      rdchk(cfb_pkg::OFS_TXERR, 8'(tec));
      mode(8'h01);
      wr(cfb_pkg::OFS_RXERR, 8'hAA);
      wr(cfb_pkg::OFS_TXERR, 8'hAA);
      rdchk(cfb_pkg::OFS_RXERR, 8'(rec));
      rdchk(cfb_pkg::OFS_TXERR, 8'(tec));
      // a good reception above the passive limit drops the count back below it
      i_cfb_bus_model.pulse(1, 129);
      i_cfb_bus_model.pulse(3, 1);
      rdchk(cfb_pkg::OFS_RXERR, cfb_pkg::ERR_PASSIVE - cfb_pkg::ERR_STEP_TX);
      $display("error counter test done");
      busoff_run(1'b0);
      busoff_run(1'b1);
      end_of_test();
   end
endmodule
`default_nettype wire
